// File: shared/alpha_pkg.sv
// Constants and carrier types for the alpha field character decoder
// How it works
// - A first byte of 80 makes each later byte pair one 16-bit code.
// - In the 80 scheme the earlier byte of a pair is the high byte.
// - Padding bytes FF and an odd trailing FF byte produce no character.
// - A first byte of 81: byte two is count, byte three base bits 14..7.
// - In the 81 scheme the base top bit and low seven bits are zero.
// - Payload byte with top bit clear gives a 7-bit default-alphabet char.
// - Payload byte with top bit set gives base plus low seven bits.
// - A first byte of 82: byte two is count, bytes three, four the base.
// - In the 82 scheme payload from byte five splits on its top bit.
// - Counted schemes decode exactly count bytes; FF inside is a character.
// - All three schemes are handled, for small and large character sets.
`default_nettype none

package alpha_pkg;

    // ==========================================================
    // Tags and padding
    localparam logic [7:0] TAG_RAW = 8'h80;
    localparam logic [7:0] TAG_HALF8 = 8'h81;
    localparam logic [7:0] TAG_HALF16 = 8'h82;
    localparam logic [7:0] PAD_BYTE = 8'hff;

    // ==========================================================
    // Field layout and sizes
    localparam int OFFSET_MSB = 6;
    localparam int SELECT_BIT = 7;
    localparam int HALF8_SHIFT = 7;
    localparam int FIFO_DEPTH = 16;
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // One byte of a record, last marks its final byte
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rec_byte_t;

    // One decoded character; alpha7 set means code holds a 7-bit
    // default-alphabet value, clear means a 16-bit code point
    typedef struct packed {
        logic alpha7;
        logic [15:0] code;
    } char_t;

    typedef enum logic [3:0] {
        S_TAG = 4'h0,
        S_RAW_HI = 4'h1,
        S_RAW_LO = 4'h2,
        S_COUNT = 4'h3,
        S_BASE_HI = 4'h4,
        S_BASE_LO = 4'h5,
        S_PAYLOAD = 4'h6,
        S_PLAIN = 4'h7,
        S_DRAIN = 4'h8
    } dec_state_t;

endpackage : alpha_pkg

`default_nettype wire

// File: hdl/alpha_decoder.sv
// Alpha field decoder with its output character FIFO
`default_nettype none

// ==========================================================
// Character FIFO
module char_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = alpha_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("char_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty = (wr_ptr_r == rd_ptr_r);
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
            rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
        end
    end
endmodule : char_fifo

// ==========================================================
// Decoder top
module alpha_decoder #(
    parameter int DEPTH = alpha_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire alpha_pkg::rec_byte_t in_byte_i,
    output logic in_ready_o,
    output logic char_valid_o,
    input wire logic char_ready_i,
    output alpha_pkg::char_t char_o
);
    // Offset into a half page: base plus the low seven bits
    function automatic logic [15:0] half_page(input logic [15:0] base,
                                              input logic [7:0] b);
        half_page = base + {9'h000, b[alpha_pkg::OFFSET_MSB:0]};
    endfunction : half_page

    function automatic alpha_pkg::char_t alpha7(input logic [7:0] b);
        alpha7.alpha7 = 1'b1;
        alpha7.code = {9'h000, b[alpha_pkg::OFFSET_MSB:0]};
    endfunction : alpha7

    alpha_pkg::dec_state_t state_r;
    alpha_pkg::dec_state_t state_nxt;
    logic mode16_r;
    logic [7:0] hi_r;
    logic [7:0] cnt_r;
    logic [15:0] base_r;

    logic fifo_ready;
    logic push_valid;
    alpha_pkg::char_t push_char;

    // Back-pressure: a byte is only taken while the FIFO has room,
    // so an emitted character is never dropped
    assign in_ready_o = fifo_ready;

    wire [7:0] b = in_byte_i.data;
    wire take = in_valid_i && fifo_ready;
    wire is_pad = (b == alpha_pkg::PAD_BYTE);
    wire is_tag = (b == alpha_pkg::TAG_RAW) ||
                  (b == alpha_pkg::TAG_HALF8) ||
                  (b == alpha_pkg::TAG_HALF16);
    wire offset_sel = b[alpha_pkg::SELECT_BIT];

    // ==========================================================
    // Character selection
    wire emit_plain = ((state_r == alpha_pkg::S_TAG) && !is_tag && !is_pad) ||
                      ((state_r == alpha_pkg::S_PLAIN) && !is_pad);
    wire emit_raw = (state_r == alpha_pkg::S_RAW_LO);
    wire emit_pay = (state_r == alpha_pkg::S_PAYLOAD);

    wire alpha_pkg::char_t raw_char = '{alpha7: 1'b0,
                                        code: {hi_r, b}};
    wire alpha_pkg::char_t off_char = '{alpha7: 1'b0,
                                        code: half_page(base_r, b)};
    wire alpha_pkg::char_t pay_char = offset_sel ? off_char
                                                 : alpha7(b);

    assign push_valid = take && (emit_plain || emit_raw || emit_pay);
    assign push_char = emit_raw ? raw_char :
                       emit_pay ? pay_char : alpha7(b);

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            alpha_pkg::S_TAG: begin
                if (b == alpha_pkg::TAG_RAW) begin
                    state_nxt = alpha_pkg::S_RAW_HI;
                end else if (b == alpha_pkg::TAG_HALF8 ||
                             b == alpha_pkg::TAG_HALF16) begin
                    state_nxt = alpha_pkg::S_COUNT;
                end else if (is_pad) begin
                    state_nxt = alpha_pkg::S_DRAIN;
                end else begin
                    state_nxt = alpha_pkg::S_PLAIN;
                end
            end
            alpha_pkg::S_RAW_HI: begin
                // A high byte of FF can only be padding
                state_nxt = is_pad ? alpha_pkg::S_DRAIN
                                   : alpha_pkg::S_RAW_LO;
            end
            alpha_pkg::S_RAW_LO: state_nxt = alpha_pkg::S_RAW_HI;
            alpha_pkg::S_COUNT: state_nxt = alpha_pkg::S_BASE_HI;
            alpha_pkg::S_BASE_HI: begin
                if (mode16_r) begin
                    state_nxt = alpha_pkg::S_BASE_LO;
                end else begin
                    state_nxt = (cnt_r == 8'h00) ? alpha_pkg::S_DRAIN
                                                 : alpha_pkg::S_PAYLOAD;
                end
            end
            alpha_pkg::S_BASE_LO: begin
                state_nxt = (cnt_r == 8'h00) ? alpha_pkg::S_DRAIN
                                             : alpha_pkg::S_PAYLOAD;
            end
            alpha_pkg::S_PAYLOAD: begin
                if (cnt_r == 8'h01) begin
                    state_nxt = alpha_pkg::S_DRAIN;
                end
            end
            alpha_pkg::S_PLAIN: begin
                if (is_pad) begin
                    state_nxt = alpha_pkg::S_DRAIN;
                end
            end
            alpha_pkg::S_DRAIN: state_nxt = alpha_pkg::S_DRAIN;
            default: state_nxt = alpha_pkg::S_TAG;
        endcase
        if (in_byte_i.last) begin
            state_nxt = alpha_pkg::S_TAG;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= alpha_pkg::S_TAG;
        end else if (take) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode16_r <= 1'b0;
            hi_r <= 8'h00;
            cnt_r <= alpha_pkg::COUNT_RESET;
            base_r <= alpha_pkg::BASE_RESET;
        end else if (take) begin
            if (state_r == alpha_pkg::S_TAG) begin
                mode16_r <= (b == alpha_pkg::TAG_HALF16);
            end
            if (state_r == alpha_pkg::S_RAW_HI) begin
                hi_r <= b;
            end
            if (state_r == alpha_pkg::S_COUNT) begin
                cnt_r <= b;
            end
            if (state_r == alpha_pkg::S_PAYLOAD) begin
                cnt_r <= cnt_r - 8'h01;
            end
            if (state_r == alpha_pkg::S_BASE_HI) begin
                base_r <= mode16_r ? {b, 8'h00}
                                   : ({8'h00, b} <<
                                      alpha_pkg::HALF8_SHIFT);
            end
            if (state_r == alpha_pkg::S_BASE_LO) begin
                base_r[7:0] <= b;
            end
        end
    end

    char_fifo #(
        .WIDTH($bits(alpha_pkg::char_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(push_char),
        .out_valid_o(char_valid_o),
        .out_ready_i(char_ready_i),
        .out_data_o(char_o)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RAW_PAIR: assert property (
        take && state_r == alpha_pkg::S_RAW_LO |->
            push_valid && push_char.code == {hi_r, b} && !push_char.alpha7)
        else $error("raw pair not emitted high byte first");
    AST_RAW_PAD: assert property (
        take && state_r == alpha_pkg::S_RAW_HI && is_pad |->
            !push_valid ##1 state_r inside {alpha_pkg::S_DRAIN,
                                            alpha_pkg::S_TAG})
        else $error("raw padding produced a character");
    AST_HALF8_BASE: assert property (
        take && state_r == alpha_pkg::S_BASE_HI && !mode16_r |=>
            base_r == {1'b0, $past(b), 7'h00})
        else $error("half page base not aligned");
    AST_COUNT_LOAD: assert property (
        take && state_r == alpha_pkg::S_COUNT && !in_byte_i.last |=>
            cnt_r == $past(b) && state_r == alpha_pkg::S_BASE_HI)
        else $error("count not captured");
    AST_HALF16_BASE: assert property (
        take && state_r == alpha_pkg::S_BASE_HI && mode16_r &&
        !in_byte_i.last ##1 take && !in_byte_i.last |=>
            base_r == {$past(b, 2), $past(b)})
        else $error("full base pointer wrong");
    AST_ALPHA7: assert property (
        take && state_r == alpha_pkg::S_PAYLOAD && !offset_sel |->
            push_valid && push_char.alpha7 &&
            push_char.code == {9'h000, b[6:0]})
        else $error("default alphabet payload wrong");
    AST_OFFSET: assert property (
        take && state_r == alpha_pkg::S_PAYLOAD && offset_sel |->
            push_valid && !push_char.alpha7 &&
            push_char.code == base_r + {9'h000, b[6:0]})
        else $error("offset character wrong");
    AST_COUNT_END: assert property (
        take && state_r == alpha_pkg::S_PAYLOAD && cnt_r == 8'h01 &&
        !in_byte_i.last |=> state_r == alpha_pkg::S_DRAIN)
        else $error("count not honoured");
    AST_PLAIN_STOP: assert property (
        take && state_r == alpha_pkg::S_PLAIN && is_pad |->
            !push_valid)
        else $error("plain padding emitted");
    AST_RECORD_END: assert property (
        take && in_byte_i.last |=> state_r == alpha_pkg::S_TAG)
        else $error("record end did not rearm decoder");
endmodule : alpha_decoder

`default_nettype wire

// File: tb/card_byte_src.sv
// Byte source standing in for the card's record storage
`default_nettype none

module card_byte_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic ready_i,
    output logic valid_o,
    output alpha_pkg::rec_byte_t byte_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Record bytes, whole records of one scheme each
    alpha_pkg::rec_byte_t q[$];

    // A byte holds until taken; an idle bus shows no stale value
    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            byte_o <= '0;
        end else if (!valid_o || ready_i) begin
            if (q.size() > 0 && !(slow_i && $urandom_range(1, 0) == 0)) begin
                valid_o <= 1'b1;
                byte_o <= q.pop_front();
            end else begin
                valid_o <= 1'b0;
                byte_o <= ~byte_o;
            end
        end
    end
endmodule : card_byte_src

`default_nettype wire

// File: tb/tb_alpha_decoder.sv
// Self-checking bench for the alpha field decoder
`default_nettype none

module tb_alpha_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Wiring
    logic clk_i;
    logic rst_i;
    logic slow_r;
    logic hold_r;
    logic stall_r;
    logic char_ready_i;
    logic in_valid_i;
    logic in_ready_o;
    logic char_valid_o;
    alpha_pkg::rec_byte_t in_byte_i;
    alpha_pkg::char_t char_o;
    alpha_pkg::char_t exp_q[$];
    logic [7:0] bq[$];
    int err_count;
    int samples_checked;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Small depth so the full case is cheap to reach
    alpha_decoder #(.DEPTH(4)) u_alpha_decoder (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(in_valid_i),
        .in_byte_i(in_byte_i),
        .in_ready_o(in_ready_o),
        .char_valid_o(char_valid_o),
        .char_ready_i(char_ready_i),
        .char_o(char_o)
    );

    card_byte_src u_card_byte_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .slow_i(slow_r),
        .ready_i(in_ready_o),
        .valid_o(in_valid_i),
        .byte_o(in_byte_i)
    );

    always @(posedge clk_i) begin
        char_ready_i <= !hold_r && (!stall_r || $urandom_range(1, 0) == 1);
    end

    // ==========================================================
    // Output monitor: every character must match the oldest note
    always @(posedge clk_i) begin
        if (!rst_i && char_valid_o === 1'b1 && char_ready_i === 1'b1) begin
            samples_checked++;
            if (exp_q.size() == 0 || char_o !== exp_q[0]) begin
                err_count++;
                $display("BAD t=%0t got %h exp %h", $time, char_o,
                         exp_q.size() > 0 ? exp_q[0] : 17'h0);
            end
            if (exp_q.size() > 0) begin
                void'(exp_q.pop_front());
            end
        end
    end

    // ==========================================================
    // Stimulus helpers
    task automatic pay(input logic [7:0] b, input logic [15:0] base);
        bq.push_back(b);
        if (b[7]) begin
            exp_q.push_back({1'b0, base + {9'h0, b[6:0]}});
        end else begin
            exp_q.push_back({1'b1, {9'h0, b[6:0]}});
        end
    endtask : pay

    task automatic gen(input int s, input int n);
        logic [7:0] a;
        logic [7:0] c;
        logic [15:0] base;
        a = 8'($urandom);
        c = 8'($urandom);
        base = (s == 1) ? {1'b0, a, 7'h0} : {a, c};
        if (s == 0) begin
            bq = '{alpha_pkg::TAG_RAW};
            repeat (n) begin
                a = 8'($urandom_range(254, 0));
                c = 8'($urandom);
                bq.push_back(a);
                bq.push_back(c);
                exp_q.push_back({1'b0, a, c});
            end
            bq.push_back(alpha_pkg::PAD_BYTE);
        end else if (s == 1) begin
            bq = '{alpha_pkg::TAG_HALF8, 8'(n), base[14:7]};
            repeat (n) pay(8'($urandom), base);
        end else begin
            bq = '{alpha_pkg::TAG_HALF16, 8'(n), a, c};
            repeat (n) pay(8'($urandom), base);
        end
    endtask : gen

    task automatic load();
        @(negedge clk_i);
        while (bq.size() > 0) begin
            u_card_byte_src.q.push_back({bq[0], bq.size() == 1});
            void'(bq.pop_front());
        end
    endtask : load

    task automatic finish_rec(input string name);
        int n;
        n = 0;
        while ((exp_q.size() > 0 || u_card_byte_src.q.size() > 0 ||
                in_valid_i) && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (8) @(posedge clk_i);
        // Look between edges, where the flags have settled
        @(negedge clk_i);
        samples_checked++;
        if (n >= 3000 || char_valid_o !== 1'b0) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, char_valid_o, 1'b0);
        end
        $display("test %s done", name);
        @(posedge clk_i);
    endtask : finish_rec

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Watchdog: seven drains of at most 3000 cycles plus traffic
    initial begin
        #500000;
        err_count++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        int n;
        err_count = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        slow_r = 1'b0;
        hold_r = 1'b0;
        stall_r = 1'b0;
        void'($urandom(32'hc29f74be));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        bq = '{8'h81, 8'h05, 8'h13};
        pay(8'h53, 16'h0980);
        pay(8'h95, 16'h0980);
        pay(8'ha6, 16'h0980);
        pay(8'h41, 16'h0980);
        pay(8'hff, 16'h0980);
        bq.push_back(8'hff);
        load();
        finish_rec("half8");
        bq = '{8'h82, 8'h05, 8'h05, 8'h30};
        pay(8'h2d, 16'h0530);
        pay(8'h82, 16'h0530);
        pay(8'hd3, 16'h0530);
        pay(8'h2d, 16'h0530);
        pay(8'h31, 16'h0530);
        load();
        finish_rec("half16");
        bq = '{8'h81, 8'h00, 8'h20, 8'h41};
        load();
        bq = '{8'h81, 8'h01, 8'hff};
        pay(8'hff, 16'h7f80);
        load();
        bq = '{8'h82, 8'h01, 8'hff, 8'hf0};
        pay(8'hff, 16'hfff0);
        load();
        finish_rec("bounds");
        bq = '{8'h80, 8'h12, 8'h34, 8'hab, 8'hcd, 8'hff, 8'hff, 8'hff};
        exp_q.push_back({1'b0, 16'h1234});
        exp_q.push_back({1'b0, 16'habcd});
        load();
        bq = '{8'h80, 8'h00, 8'h41, 8'h56};
        exp_q.push_back({1'b0, 16'h0041});
        load();
        finish_rec("raw");
        bq.delete();
        pay(8'h41, 16'h0000);
        pay(8'h42, 16'h0000);
        bq.push_back(8'hff);
        bq.push_back(8'h43);
        load();
        bq = '{8'hff, 8'h41};
        load();
        finish_rec("plain");
        hold_r <= 1'b1;
        gen(0, 10);
        load();
        n = 0;
        while (in_ready_o !== 1'b0 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        samples_checked++;
        if (in_ready_o !== 1'b0) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, in_ready_o, 1'b0);
        end
        @(posedge clk_i);
        hold_r <= 1'b0;
        finish_rec("full");
        stall_r <= 1'b1;
        slow_r <= 1'b1;
        repeat (40) begin
            gen($urandom_range(2, 0), $urandom_range(6, 0));
            load();
        end
        finish_rec("random");
        end_of_test();
    end
endmodule : tb_alpha_decoder

`default_nettype wire
